/* dv/ccs_top_sva.sv */
// concurrent checks on the clock source select ports
`timescale 1ns/10ps
`default_nettype none
module ccs_top_chk (
  // clock and reset
  input wire logic               REF_CLK,
  input wire logic               SYS_RST,
  // bus
  input wire logic               AVS_READ,
  input wire logic               AVS_WRITE,
  input wire ccs_pkg::ccs_word_t AVS_READDATA,
  input wire logic               AVS_WAITREQUEST,
  // oscillators and clocks
  input wire logic               INT_SLOW_RC_OSC,
  input wire logic               EXT_FAST_CRYSTAL_EN,
  input wire logic               INT_FAST_RC_EN,
  input wire ccs_pkg::ccs_trim_t RC_FREQ_TRIM,
  input wire logic               SYS_CLK,
  input wire logic               FAST_CLK,
  input wire logic               SUB_CLK,
  input wire logic               WDT_CLK,
  input wire logic               TIMEBASE_CLK
);
  import ccs_pkg::*;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  AST_WAIT_ONE: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low too long");
  AST_ANSWER: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
    |=> !AVS_WAITREQUEST) else $error("no answer after one cycle");
  AST_DATA_HI: assert property (AVS_READDATA[31:8] == 24'h0)
    else $error("read data upper bits set");
  AST_TRIM_HOLD: assert property ($changed(RC_FREQ_TRIM) |->
    $past(AVS_WRITE) || $past(AVS_WRITE, 2)) else $error("trim moved");
  AST_HIGH_HOLD: assert property ($rose(SYS_CLK) |=> SYS_CLK)
    else $error("short high pulse");
  AST_LOW_HOLD: assert property ($fell(SYS_CLK) |=> !SYS_CLK)
    else $error("short low pulse");
  AST_FAST_OFF: assert property ((!EXT_FAST_CRYSTAL_EN && !INT_FAST_RC_EN)
    [*4] |-> !FAST_CLK) else $error("fast clock runs while off");
  AST_WDT: assert property ($rose(WDT_CLK) |->
    $past(INT_SLOW_RC_OSC, 3)) else $error("watchdog clock not slow rc");
  AST_TB_SUB: assert property (TIMEBASE_CLK == SUB_CLK)
    else $error("time base clock not slow source");
endmodule // ccs_top_chk
bind ccs_top ccs_top_chk u_chk (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .INT_SLOW_RC_OSC(INT_SLOW_RC_OSC),
  .EXT_FAST_CRYSTAL_EN(EXT_FAST_CRYSTAL_EN), .INT_FAST_RC_EN(INT_FAST_RC_EN),
  .RC_FREQ_TRIM(RC_FREQ_TRIM), .SYS_CLK(SYS_CLK), .FAST_CLK(FAST_CLK),
  .SUB_CLK(SUB_CLK), .WDT_CLK(WDT_CLK), .TIMEBASE_CLK(TIMEBASE_CLK));
`default_nettype wire

/* dv/test_system_clock_source_select.sv */
// self-checking bench for the clock source select
`timescale 1ns/10ps
`default_nettype none
module test_system_clock_source_select;
  import ccs_pkg::*;
  logic ref_clk = 0, rst = 1, rd = 0, wr = 0;
  logic [3:0] adr = 4'h0, osc = 4'h0;
  ccs_word_t wdat = 32'h0, rdat, q;
  ccs_trim_t trim, tr, o, opt = 2'h2;
  logic sys_clk, fast_clk, xen, ren, wen, wrq, sub_clk, wdt_clk, tb_clk, mon;
  int bad_count = 0, n_tests = 0, cyc = 0, seed = 32'h9593, p, e, msel = 0;
  int per_t [4] = '{8, 12, 40, 56};
  logic [2:0] sel;
  logic high_speed_source_select, low_speed_source_select, en;
  ccs_top u_dut (.REF_CLK(ref_clk), .SYS_RST(rst), .AVS_ADDRESS(adr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_READDATA(rdat),
    .AVS_WAITREQUEST(wrq), .EXT_FAST_CRYSTAL_OSC(osc[0]),
    .INT_FAST_RC_OSC(osc[1]), .INT_SLOW_RC_OSC(osc[2]),
    .EXT_WATCH_CRYSTAL_OSC(osc[3]), .RC_FREQ_OPTION(opt),
    .EXT_FAST_CRYSTAL_EN(xen), .INT_FAST_RC_EN(ren),
    .EXT_WATCH_CRYSTAL_EN(wen), .RC_FREQ_TRIM(trim), .SYS_CLK(sys_clk),
    .FAST_CLK(fast_clk), .SUB_CLK(sub_clk), .WDT_CLK(wdt_clk),
    .TIMEBASE_CLK(tb_clk));
  // clock whose period the per task measures
  assign mon = (msel == 0) ? sys_clk : (msel == 1) ? sub_clk : wdt_clk;
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  // raw oscillators as cycle counts, and the run limit
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    for (int i = 0; i < 4; i++) begin
      osc[i] <= (cyc % per_t[i]) < per_t[i] / 2;
    end
    if (cyc == 60000) begin
      bad_count++;
      test_done;
    end
  end
  task automatic bus(input logic w, input logic [3:0] a, input ccs_word_t d);
    @(posedge ref_clk);
    adr <= a;
    wr <= w;
    rd <= !w;
    wdat <= d;
    do @(posedge ref_clk); while (wrq !== 1'b0);
    q = rdat;
    rd <= 0;
    wr <= 0;
  endtask
  task automatic chk(input string n, input ccs_word_t x, input ccs_word_t g);
    n_tests++;
    if (x !== g) begin
      $display("unexpected %s expected %h seen %h", n, x, g);
      bad_count++;
    end
  endtask
  task automatic per(input int w, output int pr);
    realtime t0;
    msel = w;
    @(posedge mon);
    t0 = $realtime;
    @(posedge mon);
    pr = int'(($realtime - t0) / 50.0);
  endtask
  task automatic test_done;
    $display("mismatches %0d comparisons %0d", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 0;
    bus(0, 4'h0, 0); chk("ctrl reset", 32'h00, q);
    bus(0, 4'h4, 0); chk("frc reset", 32'h01, q);
    bus(0, 4'hC, 0); chk("unmapped read", 32'h00, q);
    $display("register test done");
    for (int s = 0; s < 9; s++) begin
      e = $random(seed);
      sel = (s > 7) ? 3'h7 : s[2:0];
      {en, low_speed_source_select, high_speed_source_select} = e[2:0];
      // slow mode is run once with the fast oscillator kept and once stopped
      if (sel == 3'h7) en = !s[3];
      o = (e[6:5] == 2'h3) ? 2'h0 : e[6:5];
      opt <= o;
      tr = s[0] ? e[4:3] : o;
      bus(1, 4'h4, {28'h0, tr, 1'b0, en});
      bus(1, 4'h0, {24'h0, sel, 1'b0, high_speed_source_select, low_speed_source_select, 2'b00});
      repeat (3) per(0, p);
      e = (sel == 3'h7) ? per_t[2 + low_speed_source_select] : per_t[high_speed_source_select] << sel;
      chk("sys period", e, p);
      repeat (2) per(1, p);
      chk("sub period", per_t[2 + low_speed_source_select], p);
      repeat (2) per(2, p);
      chk("watchdog period", per_t[2], p);
      @(posedge ref_clk);
      chk("time base", sub_clk, tb_clk);
      bus(0, 4'h8, 0);
      e = (sel != 3'h7 || en) ? (high_speed_source_select ? 2 : 1) : 0;
      chk("status", {e != 0, tr == opt, low_speed_source_select, high_speed_source_select, sel, 1'b0}, q[7:0]);
      chk("trim", tr, trim);
      chk("enables", {low_speed_source_select, e[1:0]}, {wen, ren, xen});
      if (e == 0) chk("fast stopped", 0, fast_clk);
      $display("select test %0d done", s);
    end
    // reset again in mid-run: registers and enables return to reset state
    rst <= 1;
    repeat (2) @(posedge ref_clk);
    rst <= 0;
    bus(0, 4'h0, 0); chk("ctrl after reset", 32'h00, q);
    chk("enables after reset", 3'b001, {wen, ren, xen});
    $display("reset test done");
    test_done;
  end
endmodule // test_system_clock_source_select
`default_nettype wire

/* hw/ccs_osc_sync.sv */
// two-flop synchroniser with rising-edge pulse for raw oscillator inputs
`timescale 1ns/10ps
`default_nettype none
module ccs_osc_sync #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // raw oscillator levels
  input  wire logic [WIDTH-1:0] raw_i,
  // synchronised level and rising edge
  output logic      [WIDTH-1:0] lvl_o,
  output logic      [WIDTH-1:0] rise_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] lvl_q;
  logic [WIDTH-1:0] prev_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '0;
      lvl_q  <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= raw_i;
      lvl_q  <= meta_q;
      prev_q <= lvl_q;
    end
  end

  assign lvl_o  = lvl_q;
  assign rise_o = lvl_q & ~prev_q;
endmodule // ccs_osc_sync
`default_nettype wire

/* hw/ccs_pkg.sv */
// types shared by the clock source select files
package ccs_pkg;
  typedef logic [2:0] ccs_cks_t;
  typedef logic [1:0] ccs_trim_t;
  typedef logic [31:0] ccs_word_t;
endpackage

/* hw/ccs_regs.svh */
// register offsets, field positions and reset values of the clock source select
`ifndef CCS_REGS_SVH
`define CCS_REGS_SVH

`define CCS_ADDR_W        4
`define CCS_OFS_CTRL      4'h0
`define CCS_OFS_FRC       4'h4
`define CCS_OFS_STAT      4'h8

`define CCS_CTRL_CKS_LSB  5
`define CCS_CTRL_FHS_BIT  3
`define CCS_CTRL_FSS_BIT  2
`define CCS_CTRL_RST      8'h00

`define CCS_FRC_EN_BIT    0
`define CCS_FRC_TRIM_LSB  2
`define CCS_FRC_RST       8'h01

`define CCS_STAT_PEND_BIT 0
`define CCS_STAT_CKS_LSB  1
`define CCS_STAT_FHS_BIT  4
`define CCS_STAT_FSS_BIT  5
`define CCS_STAT_TOK_BIT  6
`define CCS_STAT_RUN_BIT  7

`define CCS_CKS_SUB       3'h7
`define CCS_CKS_FULL      3'h0

`endif

/* hw/ccs_top.sv */
// system clock source and frequency select with avalon-mm registers
//
// Local design decisions: the Avalon-MM register port and the register offsets.
`include "ccs_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module ccs_top (
  // clock and reset
  input  wire logic             REF_CLK,
  input  wire logic             SYS_RST,
  // avalon-mm slave
  input  wire logic [`CCS_ADDR_W-1:0] AVS_ADDRESS,
  input  wire logic             AVS_READ,
  input  wire logic             AVS_WRITE,
  input  wire ccs_pkg::ccs_word_t AVS_WRITEDATA,
  output ccs_pkg::ccs_word_t    AVS_READDATA,
  output logic                  AVS_WAITREQUEST,
  // raw oscillator clocks
  input  wire logic             EXT_FAST_CRYSTAL_OSC,
  input  wire logic             INT_FAST_RC_OSC,
  input  wire logic             INT_SLOW_RC_OSC,
  input  wire logic             EXT_WATCH_CRYSTAL_OSC,
  // configuration option for the fast rc frequency
  input  wire ccs_pkg::ccs_trim_t RC_FREQ_OPTION,
  // oscillator enables and fast rc trim
  output logic                  EXT_FAST_CRYSTAL_EN,
  output logic                  INT_FAST_RC_EN,
  output logic                  EXT_WATCH_CRYSTAL_EN,
  output ccs_pkg::ccs_trim_t    RC_FREQ_TRIM,
  // generated clocks
  output logic                  SYS_CLK,
  output logic                  FAST_CLK,
  output logic                  SUB_CLK,
  output logic                  WDT_CLK,
  output logic                  TIMEBASE_CLK
);
  import ccs_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] ctrl_q;
  logic [7:0] frc_q;
  logic       wait_q;
  ccs_word_t  rdata_q;
  ccs_cks_t   act_cks_q;
  logic       act_fhs_q;
  logic       act_fss_q;
  logic [5:0] div_q;
  logic       sys_q;
  logic       fast_q;
  logic       sub_q;
  logic       wdt_q;
  logic       tb_q;
  logic       hxt_en_q;
  logic       int_fast_rc_osc_en_q;
  logic       lxt_en_q;

  logic [3:0] osc_lvl;
  logic [3:0] osc_rise;
  ccs_cks_t   req_cks;
  logic       req_fhs;
  logic       req_fss;
  logic       pend;
  logic       fh_lvl;
  logic       fh_rise;
  logic       fsub_lvl;
  logic       cand;
  logic       fast_run;
  logic       trim_ok;
  logic [7:0] stat;

  function automatic logic pick_clk(input ccs_cks_t cks, input logic fh,
                                    input logic fsub, input logic [5:0] div);
    logic r;
    r = fh;
    if (cks == `CCS_CKS_SUB)
      r = fsub;
    else if (cks != `CCS_CKS_FULL)
      r = div[cks - 3'h1];
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // oscillator sampling
  ccs_osc_sync #(.WIDTH(4)) u_sync (
    .clk    (REF_CLK),
    .rst    (SYS_RST),
    .raw_i  ({EXT_WATCH_CRYSTAL_OSC, INT_SLOW_RC_OSC,
              INT_FAST_RC_OSC, EXT_FAST_CRYSTAL_OSC}),
    .lvl_o  (osc_lvl),
    .rise_o (osc_rise)
  );

  assign req_cks  = ctrl_q[`CCS_CTRL_CKS_LSB +: 3];
  assign req_fhs  = ctrl_q[`CCS_CTRL_FHS_BIT];
  assign req_fss  = ctrl_q[`CCS_CTRL_FSS_BIT];
  // single select bits always name one source per path
  assign fh_lvl   = act_fhs_q ? osc_lvl[1] : osc_lvl[0];
  assign fh_rise  = act_fhs_q ? osc_rise[1] : osc_rise[0];
  assign fsub_lvl = act_fss_q ? osc_lvl[3] : osc_lvl[2];
  assign pend     = (req_cks != act_cks_q) | (req_fhs != act_fhs_q)
                  | (req_fss != act_fss_q);
  assign cand     = pick_clk(req_cks, req_fhs ? osc_lvl[1] : osc_lvl[0],
                             req_fss ? osc_lvl[3] : osc_lvl[2], div_q);
  // fast oscillator kept alive while in use or while enabled
  assign fast_run = frc_q[`CCS_FRC_EN_BIT] | (act_cks_q != `CCS_CKS_SUB);
  assign trim_ok  = frc_q[`CCS_FRC_TRIM_LSB +: 2] == RC_FREQ_OPTION;
  assign stat     = {fast_run, trim_ok, act_fss_q, act_fhs_q, act_cks_q, pend};

  //////////////////////////////////////////////////////////////////////////////
  // avalon-mm slave: one wait cycle, then answer
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST)
      wait_q <= 1'b1;
    else if ((AVS_READ | AVS_WRITE) & wait_q)
      wait_q <= 1'b0;
    else
      wait_q <= 1'b1;
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST)
      rdata_q <= '0;
    else if (AVS_READ & wait_q) begin
      case (AVS_ADDRESS)
        `CCS_OFS_CTRL: rdata_q <= {24'h000000, ctrl_q};
        `CCS_OFS_FRC:  rdata_q <= {24'h000000, frc_q};
        `CCS_OFS_STAT: rdata_q <= {24'h000000, stat};
        default:       rdata_q <= '0;
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      ctrl_q <= `CCS_CTRL_RST;
      frc_q  <= `CCS_FRC_RST;
    end else if (AVS_WRITE & ~wait_q) begin
      if (AVS_ADDRESS == `CCS_OFS_CTRL)
        ctrl_q <= {AVS_WRITEDATA[7:5], 1'b0, AVS_WRITEDATA[3:2], 2'b00};
      if (AVS_ADDRESS == `CCS_OFS_FRC)
        frc_q <= {4'h0, AVS_WRITEDATA[3:2], 1'b0, AVS_WRITEDATA[0]};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // fast clock divider, counts edges of the active fast source
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST)
      div_q <= '0;
    else if (fh_rise)
      div_q <= div_q + 6'h01;
  end

  //////////////////////////////////////////////////////////////////////////////
  // selection changes only while both old and new clocks sit low
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      act_cks_q <= `CCS_CKS_FULL;
      act_fhs_q <= 1'b0;
      act_fss_q <= 1'b0;
    end else if (pend & ~sys_q & ~cand) begin
      act_cks_q <= req_cks;
      act_fhs_q <= req_fhs;
      act_fss_q <= req_fss;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST)
      sys_q <= 1'b0;
    else if (pend & ~sys_q)
      sys_q <= 1'b0;
    else
      sys_q <= pick_clk(act_cks_q, fh_lvl, fsub_lvl, div_q);
  end

  //////////////////////////////////////////////////////////////////////////////
  // peripheral clocks and oscillator enables
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      fast_q <= 1'b0;
      sub_q  <= 1'b0;
      wdt_q  <= 1'b0;
      tb_q   <= 1'b0;
    end else begin
      fast_q <= fh_lvl & fast_run;
      sub_q  <= fsub_lvl;
      wdt_q  <= osc_lvl[2];
      tb_q   <= fsub_lvl;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      hxt_en_q  <= 1'b1;
      int_fast_rc_osc_en_q <= 1'b0;
      lxt_en_q  <= 1'b0;
    end else begin
      hxt_en_q  <= fast_run & (~req_fhs | ~act_fhs_q);
      int_fast_rc_osc_en_q <= fast_run & (req_fhs | act_fhs_q);
      lxt_en_q  <= req_fss | act_fss_q;
    end
  end

  assign AVS_READDATA         = rdata_q;
  assign AVS_WAITREQUEST      = wait_q;
  assign EXT_FAST_CRYSTAL_EN  = hxt_en_q;
  assign INT_FAST_RC_EN       = int_fast_rc_osc_en_q;
  assign EXT_WATCH_CRYSTAL_EN = lxt_en_q;
  assign RC_FREQ_TRIM         = frc_q[`CCS_FRC_TRIM_LSB +: 2];
  assign SYS_CLK              = sys_q;
  assign FAST_CLK             = fast_q;
  assign SUB_CLK              = sub_q;
  assign WDT_CLK              = wdt_q;
  assign TIMEBASE_CLK         = tb_q;
endmodule // ccs_top
`default_nettype wire
